// file: rgs_pkg.sv
// rgs_pkg: constants shared by the receive gain, squelch and peak level logic
package rgs_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_NS     = 50;
  localparam int unsigned SQ_WIN_NS  = 50000;
  localparam int unsigned SQ_DLY_PS  = 18880000;
  localparam int unsigned SQ_WIN_CYC = SQ_WIN_NS / CLK_NS;
  localparam int unsigned SQ_DLY_CYC = (SQ_DLY_PS + CLK_NS * 1000 - 1) / (CLK_NS * 1000);
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CFG  = 8'h00;
  localparam logic [7:0] OFS_CMD  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  // ==========================================================
  // config register fields
  localparam int unsigned CFG_AGC_EN   = 0;
  localparam int unsigned CFG_AGC_MODE = 1;
  localparam int unsigned CFG_AGC_ALG  = 2;
  localparam int unsigned CFG_SQ_DYN   = 3;
  localparam int unsigned CFG_CLIP     = 4;
  localparam int unsigned CFG_PEER_GF  = 5;
  localparam int unsigned CFG_PEER_MD  = 6;
  localparam int unsigned CFG_MAN_LSB  = 8;
  localparam logic [11:0] CFG_RST      = 12'h005;
  // ==========================================================
  // command register bits, write one to fire
  localparam int unsigned CMD_SQUELCH  = 0;
  localparam int unsigned CMD_RESTORE  = 1;
  localparam int unsigned CMD_PK_CLR   = 2;
  localparam int unsigned CMD_PRESET   = 3;
  // ==========================================================
  // status register fields
  localparam int unsigned STAT_GAIN_LSB = 0;
  localparam int unsigned STAT_CAPT_LSB = 4;
  localparam int unsigned STAT_PEAK_LSB = 8;
  localparam int unsigned STAT_SQ_BUSY  = 12;
  // ==========================================================
  // gain state and output codes, peak, pulse and squelch limits, squelch states
  localparam logic [3:0] GAIN_MAX   = 4'ha;
  localparam logic [3:0] GAIN_WIN   = 4'h4;
  localparam logic [3:0] GAIN_ZERO  = 4'h0;
  localparam logic [2:0] WIN_MAX    = 3'h4;
  localparam logic [2:0] PEER_RED   = 3'h2;
  localparam logic [3:0] PEAK_MAX   = 4'hd;
  localparam logic [3:0] SUBC_AGC   = 4'h8;
  localparam logic [1:0] SQ_THRESH  = 2'h2;

  typedef enum logic [2:0] {
    RGS_SQ_IDLE = 3'b001,
    RGS_SQ_DLY  = 3'b010,
    RGS_SQ_RUN  = 3'b100
  } rgs_sq_st_t;
endpackage : rgs_pkg

// file: rgs_edge_det.sv
// rgs_edge_det: synchroniser and both-edge detector for a comparator output
module rgs_edge_det
  import rgs_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // comparator pin and detected transition
  input  wire logic din,
  output logic      edge_p
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================
  // two flops before any logic looks at the pin
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign edge_p = s2_q ^ s3_q; // R24
endmodule : rgs_edge_det

// file: rgs_gain_ctrl.sv
// rgs_gain_ctrl: squelch, gain control and peak level meter with APB registers
// ==========================================================
// What this block does
// R1: squelch counts transitions per window, steps gain
// R2: squelch stops at two or fewer, or maximum
// R3: restore command drops squelch gain reduction
// R4: dynamic squelch starts after delay, ends at mask
// R5: squelch command only while receive is off
// R6: gain control starts on receive rise, resets on fall
// R7: receive fall captures gain into readable state
// R8: gain control reduces while wide comparator toggles
// R9: enable, mode and algorithm bits govern gain control
// R10: mode selects whole receive or eight pulses
// R11: algorithm starts at code four or zero
// R12: reset: enabled, whole receive, preset start
// R13: host picks preset for short frame starts
// R14: peak meter runs in receive, holds otherwise
// R15: peak hold restarts when gain control reduces
// R16: four-bit peak code, never above thirteen
// R17: peak clear command zeroes and restarts meter
// R18: filter preset loads peer receive settings
// R19: clip bit enables limiting after stages
// R20: forced peer gain fixes reduction, maximum window
// R21: eleven gain steps: window then stage reduction
// R22: restore loads manual gain into shadow state
// R23: host disables gain control during anticollision
// R24: both comparator edges counted after synchronising
module rgs_gain_ctrl
  import rgs_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // receive framing, same clock
  input  wire logic        rx_on,
  input  wire logic        tx_end,
  input  wire logic        mask_rx_exp,
  input  wire logic        subc_pulse,
  // analog comparators and level codes, asynchronous
  input  wire logic        dig_cmp,
  input  wire logic        agc_cmp,
  input  wire logic [3:0]  lvl_a,
  input  wire logic [3:0]  lvl_b,
  // analog gain controls
  output logic      [3:0]  gain_state,
  output logic      [2:0]  dig_win,
  output logic      [2:0]  stage23_red,
  output logic             clip_en
);
  // ==========================================================
  // declarations
  rgs_sq_st_t  st_q;
  rgs_sq_st_t  st_d;
  logic [11:0] cfg_q;
  logic [3:0]  gain_q;
  logic [3:0]  base_q;
  logic [3:0]  capt_q;
  logic [3:0]  peak_q;
  logic [3:0]  subc_q;
  logic [9:0]  win_q;
  logic [8:0]  dly_q;
  logic [1:0]  tcnt_q;
  logic        rx_on_q;
  logic [3:0]  lvl_a1_q;
  logic [3:0]  lvl_a2_q;
  logic [3:0]  lvl_b1_q;
  logic [3:0]  lvl_b2_q;
  logic        dig_edge;
  logic        agc_edge;

  // ==========================================================
  // comparator edge detectors
  rgs_edge_det u_dig (
    .mclk   (mclk),
    .rst    (rst),
    .din    (dig_cmp),
    .edge_p (dig_edge)
  );

  rgs_edge_det u_agc (
    .mclk   (mclk),
    .rst    (rst),
    .din    (agc_cmp),
    .edge_p (agc_edge)
  );

  // ==========================================================
  // apb decode
  wire acc      = psel & penable & pready;
  wire wr       = acc & pwrite;
  wire hit_cfg  = (paddr == OFS_CFG);
  wire hit_cmd  = (paddr == OFS_CMD);
  wire hit_stat = (paddr == OFS_STAT);
  wire mapped   = hit_cfg | hit_cmd | hit_stat;
  wire wr_cfg   = wr & hit_cfg;
  wire wr_cmd   = wr & hit_cmd;
  wire cmd_sq   = wr_cmd & pwdata[CMD_SQUELCH];
  wire cmd_rst  = wr_cmd & pwdata[CMD_RESTORE];
  wire cmd_pclr = wr_cmd & pwdata[CMD_PK_CLR];
  wire cmd_pre  = wr_cmd & pwdata[CMD_PRESET];

  wire [3:0]  man_gain = cfg_q[CFG_MAN_LSB +: 4];
  wire        agc_en   = cfg_q[CFG_AGC_EN];
  wire        agc_alg  = cfg_q[CFG_AGC_ALG];
  wire [31:0] stat_w   = {19'h00000, (st_q != RGS_SQ_IDLE), peak_q, capt_q, gain_q};
  wire [31:0] rd_w     = hit_cfg  ? {20'h00000, cfg_q} :
                         hit_stat ? stat_w : 32'h00000000;

  // ==========================================================
  // receive edges and squelch window
  wire rx_rise  = rx_on & ~rx_on_q;
  wire rx_fall  = ~rx_on & rx_on_q;
  wire win_end  = (st_q == RGS_SQ_RUN) && (win_q == 10'(SQ_WIN_CYC - 1));
  wire sq_noisy = tcnt_q > SQ_THRESH;
  wire sq_step  = win_end & sq_noisy & (gain_q < GAIN_MAX);
  // ==========================================================
  // gain control activity
  wire agc_act  = agc_en & rx_on_q & rx_on & (~cfg_q[CFG_AGC_MODE] | (subc_q < SUBC_AGC)); // R10
  wire agc_step = agc_act & agc_edge & (gain_q < GAIN_MAX);       // R8
  wire [3:0] agc_start = agc_alg ? GAIN_WIN : GAIN_ZERO;          // R11
  wire [3:0] lvl_max   = (lvl_a2_q > lvl_b2_q) ? lvl_a2_q : lvl_b2_q;
  wire [3:0] lvl_cl    = (lvl_max > PEAK_MAX) ? PEAK_MAX : lvl_max; // R16

  // ==========================================================
  // apb answer: one access cycle, no wait from the master's view
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_w : 32'h00000000;
    end
  end

  // ==========================================================
  // configuration register
  always_ff @(posedge mclk)
  begin
    if (rst)
      cfg_q <= CFG_RST; // R12
    else if (wr_cfg)
      cfg_q <= {pwdata[11:8], 1'b0, pwdata[6:0]}; // R9
    else if (cmd_pre & cfg_q[CFG_PEER_MD])
    begin
      cfg_q[CFG_CLIP]    <= 1'b1; // R18
      cfg_q[CFG_PEER_GF] <= 1'b1; // R18
    end
  end

  // ==========================================================
  // synchronisers for level codes; quasi-static between samples
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lvl_a1_q <= 4'h0;
      lvl_a2_q <= 4'h0;
      lvl_b1_q <= 4'h0;
      lvl_b2_q <= 4'h0;
      rx_on_q  <= 1'b0;
    end
    else
    begin
      lvl_a1_q <= lvl_a;
      lvl_a2_q <= lvl_a1_q;
      lvl_b1_q <= lvl_b;
      lvl_b2_q <= lvl_b1_q;
      rx_on_q  <= rx_on;
    end
  end

  // ==========================================================
  // squelch state machine
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      RGS_SQ_IDLE:
        if (cmd_sq & ~rx_on)
          st_d = RGS_SQ_RUN; // R5
        else if (tx_end & cfg_q[CFG_SQ_DYN])
          st_d = RGS_SQ_DLY; // R4
      RGS_SQ_DLY:
        if (mask_rx_exp)
          st_d = RGS_SQ_IDLE; // R4
        else if (dly_q == 9'(SQ_DLY_CYC - 1))
          st_d = RGS_SQ_RUN; // R4
      RGS_SQ_RUN:
        if (mask_rx_exp | cmd_rst)
          st_d = RGS_SQ_IDLE; // R4
        else if (win_end & ~sq_step)
          st_d = RGS_SQ_IDLE; // R2
      default:
        st_d = RGS_SQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st_q <= RGS_SQ_IDLE;
    else
      st_q <= st_d;
  end

  // ==========================================================
  // squelch counters; window restarts after each step
  always_ff @(posedge mclk)
  begin
    if (rst || st_q != RGS_SQ_DLY)
      dly_q <= 9'h000;
    else
      dly_q <= dly_q + 9'h001;
  end

  always_ff @(posedge mclk)
  begin
    if (rst || st_q != RGS_SQ_RUN || win_end)
    begin
      win_q  <= 10'h000;
      tcnt_q <= 2'h0;
    end
    else
    begin
      win_q <= win_q + 10'h001;
      if (dig_edge && tcnt_q != 2'h3)
        tcnt_q <= tcnt_q + 2'h1; // R1
    end
  end

  // ==========================================================
  // sub-carrier pulse count within one reception
  always_ff @(posedge mclk)
  begin
    if (rst || rx_rise)
      subc_q <= 4'h0;
    else if (rx_on && subc_pulse && subc_q != SUBC_AGC)
      subc_q <= subc_q + 4'h1; // R10
  end

  // ==========================================================
  // shadow gain: squelch accumulates, restore reloads manual value
  always_ff @(posedge mclk)
  begin
    if (rst)
      base_q <= GAIN_ZERO;
    else if (cmd_rst)
      base_q <= man_gain; // R3 R22
    else if (sq_step)
      base_q <= gain_q + 4'h1; // R1
  end

  // ==========================================================
  // live gain state
  always_ff @(posedge mclk)
  begin
    if (rst)
      gain_q <= GAIN_ZERO;
    else if (cmd_rst)
      gain_q <= man_gain; // R3
    else if (sq_step)
      gain_q <= gain_q + 4'h1; // R1
    else if (rx_rise & agc_en)
      gain_q <= agc_start; // R6 R11
    else if (rx_fall)
      gain_q <= base_q; // R6
    else if (agc_step)
      gain_q <= gain_q + 4'h1; // R8
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      capt_q <= GAIN_ZERO;
    else if (rx_fall)
      capt_q <= gain_q; // R7
  end

  // ==========================================================
  // peak hold meter; clear wins over any update
  always_ff @(posedge mclk)
  begin
    if (rst || cmd_pclr)
      peak_q <= 4'h0; // R17
    else if (rx_rise || agc_step)
      peak_q <= 4'h0; // R14 R15
    else if (rx_on && rx_on_q && lvl_cl > peak_q)
      peak_q <= lvl_cl; // R14 R16
  end

  // ==========================================================
  // analog gain outputs; window saturates before stage reduction
  wire [2:0] win_c = (gain_q > GAIN_WIN) ? WIN_MAX : gain_q[2:0];              // R21
  wire [2:0] red_c = (gain_q > GAIN_WIN) ? 3'(gain_q - GAIN_WIN) : 3'h0;       // R21

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      gain_state  <= GAIN_ZERO;
      dig_win     <= 3'h0;
      stage23_red <= 3'h0;
      clip_en     <= 1'b0;
    end
    else
    begin
      gain_state  <= gain_q;
      dig_win     <= cfg_q[CFG_PEER_GF] ? WIN_MAX : win_c;  // R20
      stage23_red <= cfg_q[CFG_PEER_GF] ? PEER_RED : red_c; // R20
      clip_en     <= cfg_q[CFG_CLIP]; // R19
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_sq_step;
    win_end && tcnt_q > 2'h2 && gain_q < GAIN_MAX && !cmd_rst && !mask_rx_exp |=> gain_q == $past(gain_q) + 4'h1;
  endproperty
  a_sq_step: assert property (p_sq_step) else $error("squelch did not step gain"); // R1

  property p_sq_stop;
    win_end && (tcnt_q <= 2'h2 || gain_q == GAIN_MAX) |=> st_q == RGS_SQ_IDLE;
  endproperty
  a_sq_stop: assert property (p_sq_stop) else $error("squelch did not stop"); // R2

  property p_restore;
    cmd_rst |=> gain_q == $past(man_gain) && base_q == $past(man_gain);
  endproperty
  a_restore: assert property (p_restore) else $error("restore did not load manual gain"); // R3

  property p_dyn_entry;
    st_q == RGS_SQ_IDLE && tx_end && cfg_q[CFG_SQ_DYN] && !cmd_sq && !mask_rx_exp
      |=> st_q == RGS_SQ_DLY && dly_q == 9'h000;
  endproperty
  a_dyn_entry: assert property (p_dyn_entry) else $error("squelch delay not started"); // R4

  // delay length is carried by dly_q, far too long to unroll as a plain delay
  property p_dyn_wait;
    st_q == RGS_SQ_DLY && dly_q != 9'(SQ_DLY_CYC - 1) && !mask_rx_exp
      |=> st_q == RGS_SQ_DLY && dly_q == $past(dly_q) + 9'h001;
  endproperty
  a_dyn_wait: assert property (p_dyn_wait) else $error("squelch delay ended early"); // R4

  property p_dyn_delay;
    st_q == RGS_SQ_DLY && dly_q == 9'(SQ_DLY_CYC - 1) && !mask_rx_exp |=> st_q == RGS_SQ_RUN;
  endproperty
  a_dyn_delay: assert property (p_dyn_delay) else $error("squelch delay wrong"); // R4

  property p_cmd_rxon;
    st_q == RGS_SQ_IDLE && cmd_sq && rx_on && !(tx_end && cfg_q[CFG_SQ_DYN]) |=> st_q == RGS_SQ_IDLE;
  endproperty
  a_cmd_rxon: assert property (p_cmd_rxon) else $error("squelch taken during receive"); // R5

  property p_capture;
    rx_fall |=> capt_q == $past(gain_q);
  endproperty
  a_capture: assert property (p_capture) else $error("gain not captured at receive end"); // R7

  property p_agc_start;
    rx_rise && agc_en && !cmd_rst && !sq_step |=> gain_q == (agc_alg ? GAIN_WIN : GAIN_ZERO);
  endproperty
  a_agc_start: assert property (p_agc_start) else $error("wrong gain control start code"); // R11

  property p_peak_max;
    peak_q <= PEAK_MAX;
  endproperty
  a_peak_max: assert property (p_peak_max) else $error("peak code above limit"); // R16

  property p_peak_clr;
    cmd_pclr |=> peak_q == 4'h0;
  endproperty
  a_peak_clr: assert property (p_peak_clr) else $error("peak clear ignored"); // R17

  property p_peak_hold;
    !rx_on && !rx_on_q && !cmd_pclr |=> $stable(peak_q);
  endproperty
  a_peak_hold: assert property (p_peak_hold) else $error("peak changed outside receive"); // R14

  property p_peer_force;
    cfg_q[CFG_PEER_GF] |=> dig_win == WIN_MAX && stage23_red == PEER_RED;
  endproperty
  a_peer_force: assert property (p_peer_force) else $error("forced peer gain not applied"); // R20
endmodule : rgs_gain_ctrl

// file: rgs_afe_model.sv
// rgs_afe_model: comparator model of the analog receive chain
module rgs_afe_model
  import rgs_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // gain applied and the level at which noise or overload dies out
  input  wire logic [3:0] gain_state,
  input  wire logic [3:0] noise_lim,
  input  wire logic [3:0] sat_lim,
  // comparator outputs
  output logic            dig_cmp,
  output logic            agc_cmp
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [5:0] cnt_q;

  initial
  begin
    cnt_q = 6'h00;
    dig_cmp = 1'b0;
    agc_cmp = 1'b0;
  end

  // ==========================================================
  // comparators toggle until enough gain reduction is applied
  // a quiet comparator holds its last level, as a real one does
  always @(posedge mclk)
  begin
    cnt_q <= cnt_q + 6'h01;
    if (cnt_q == 6'h00 && gain_state < noise_lim)
      dig_cmp <= ~dig_cmp;
    if (cnt_q[4:0] == 5'h00 && gain_state < sat_lim)
      agc_cmp <= ~agc_cmp;
  end
endmodule : rgs_afe_model

// file: tb.sv
// tb: self-checking bench for the receive gain control block
module tb
  import rgs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, sl;
  logic        rx_on, tx_end, mask_rx_exp, subc_pulse, dig_cmp, agc_cmp, clip_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  lvl_a, lvl_b, gain_state, noise_lim, sat_lim;
  logic [2:0]  dig_win, stage23_red;
  int          mismatches, total_checks, cycles;

  rgs_gain_ctrl uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_on(rx_on), .tx_end(tx_end), .mask_rx_exp(mask_rx_exp), .subc_pulse(subc_pulse),
    .dig_cmp(dig_cmp), .agc_cmp(agc_cmp), .lvl_a(lvl_a), .lvl_b(lvl_b), .gain_state(gain_state),
    .dig_win(dig_win), .stage23_red(stage23_red), .clip_en(clip_en));

  rgs_afe_model afe (.mclk(mclk), .gain_state(gain_state), .noise_lim(noise_lim),
    .sat_lim(sat_lim), .dig_cmp(dig_cmp), .agc_cmp(agc_cmp));

  // ==========================================================
  // clock and hang guard
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      results();
    end
  end

  // ==========================================================
  // tasks
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // pready, prdata and pslverr are taken at the rising edge that ends the access phase
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, r);
  endtask : rdc

  task automatic cmd(input int unsigned b);
    apb(1'b1, OFS_CMD, 32'h1 << b);
  endtask : cmd

  task automatic tend(input string n);
    $display("test %s done", n);
  endtask : tend

  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, rx_on, tx_end, mask_rx_exp, subc_pulse} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {lvl_a, lvl_b, noise_lim, sat_lim} = 16'h0;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    cyc(2);
    rst <= 1'b0;
    rdc(OFS_CFG, 32'(CFG_RST), "cfg_reset");
    rdc(OFS_CMD, 32'h0, "cmd_read");
    rdc(OFS_STAT, 32'h0, "stat_reset");
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped_err", 32'h1, 32'(sl));
    tend("registers");
    noise_lim <= 4'h3;
    cmd(CMD_SQUELCH);
    cyc(4100);
    rdc(OFS_STAT, 32'h3, "squelch_stop");
    noise_lim <= 4'hf;
    cmd(CMD_SQUELCH);
    cyc(8100);
    rdc(OFS_STAT, 32'ha, "squelch_max");
    chk("win_max", 32'h4, 32'(dig_win));
    chk("red_max", 32'h6, 32'(stage23_red));
    apb(1'b1, OFS_CFG, 32'h505);
    cmd(CMD_RESTORE);
    rdc(OFS_STAT, 32'h5, "restore");
    chk("red_one", 32'h1, 32'(stage23_red));
    apb(1'b1, OFS_CFG, 32'h005);
    cmd(CMD_RESTORE);
    apb(1'b1, OFS_CFG, 32'h004);
    rx_on <= 1'b1;
    cmd(CMD_SQUELCH);
    cyc(1100);
    rdc(OFS_STAT, 32'h0, "squelch_refused");
    rx_on <= 1'b0;
    noise_lim <= 4'h0;
    tend("squelch");
    apb(1'b1, OFS_CFG, 32'h005);
    lvl_a <= 4'hc;
    lvl_b <= 4'h3;
    rx_on <= 1'b1;
    cyc(20);
    rdc(OFS_STAT, 32'hc04, "agc_start");
    lvl_a <= 4'h7;
    sat_lim <= 4'h6;
    cyc(300);
    rdc(OFS_STAT, 32'h706, "agc_reduce");
    rx_on <= 1'b0;
    sat_lim <= 4'h0;
    cyc(5);
    rdc(OFS_STAT, 32'h760, "agc_capture");
    lvl_b <= 4'hf;
    cyc(10);
    rdc(OFS_STAT, 32'h760, "peak_frozen");
    cmd(CMD_PK_CLR);
    rdc(OFS_STAT, 32'h060, "peak_clear");
    apb(1'b1, OFS_CFG, 32'h001);
    rx_on <= 1'b1;
    cyc(10);
    rdc(OFS_STAT, 32'hd60, "alg_zero");
    rx_on <= 1'b0;
    apb(1'b1, OFS_CFG, 32'h007);
    rx_on <= 1'b1;
    repeat (8)
    begin
      @(posedge mclk);
      subc_pulse <= 1'b1;
      @(posedge mclk);
      subc_pulse <= 1'b0;
    end
    sat_lim <= 4'h8;
    cyc(300);
    chk("agc_pulses", 32'h4, 32'(gain_state));
    rx_on <= 1'b0;
    sat_lim <= 4'h0;
    tend("agc");
    apb(1'b1, OFS_CFG, 32'h00d);
    noise_lim <= 4'h2;
    @(posedge mclk);
    tx_end <= 1'b1;
    @(posedge mclk);
    tx_end <= 1'b0;
    // first step lands 378 delay plus 1000 window cycles after tx_end
    cyc(1372);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("dyn_wait", 32'h1000, {19'h0, r[12], 8'h0, r[3:0]});
    cyc(4);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("dyn_run", 32'h1001, {19'h0, r[12], 8'h0, r[3:0]});
    mask_rx_exp <= 1'b1;
    @(posedge mclk);
    mask_rx_exp <= 1'b0;
    cyc(3);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("dyn_end", 32'h1, {19'h0, r[12], 8'h0, r[3:0]});
    noise_lim <= 4'h0;
    tend("dynamic");
    apb(1'b1, OFS_CFG, 32'h045);
    cmd(CMD_PRESET);
    cyc(3);
    chk("clip", 32'h1, 32'(clip_en));
    chk("peer_win", 32'h4, 32'(dig_win));
    chk("peer_red", 32'h2, 32'(stage23_red));
    rdc(OFS_CFG, 32'h075, "preset_cfg");
    tend("preset");
    results();
  end
endmodule : tb
